// ===== hw/hts_i2c_sensor_ctrl.sv
// serial register slave with the two-sensor measurement sequencer
// Notes on behaviour
// RULE1 - works at 100 and 400 kbit/s
// RULE2 - never holds the clock line low
// RULE3 - 7-bit address only, no optional features
// RULE4 - answers only bus address 0x43
// RULE5 - byte addresses and byte data, 256 locations
// RULE6 - write: ack address and load pointer
// RULE7 - write data at pointer, ack, then increment
// RULE8 - nack and ignore writes to protected addresses
// RULE9 - read returns byte at pointer, then increments
// RULE10 - reserved addresses read as zero
// RULE11 - per-sensor single-shot or continuous mode
// RULE12 - single-shot: one measurement, stop ignored
// RULE13 - status bit shows each sensor measuring
// RULE14 - continuous repeats until stop, after measurement
// RULE15 - at step end, re-examine or enter standby
// RULE16 - repeated start/stop act once per step
// RULE17 - start clears valid, boots, then measures
// RULE18 - single-shot end: valid, standby, bits clear
// RULE19 - continuous: valid stays set across updates
// RULE20 - continuous stop: last update, standby, bits clear
// RULE21 - control writes act only between measurements
// RULE22 - master keeps stop low for continuous
// RULE23 - readout holds data, valid, crc-7
// RULE24 - lowest byte read snapshots whole readout
// RULE25 - pins synchronised and filtered before edges
module hts_i2c_sensor_ctrl #(
   parameter int unsigned BOOT_CYCLES = hts_pkg::BOOT_CYCLES_DEF
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic [1:0] i_meas_done,
   input wire logic [15:0] i_t_result,
   input wire logic [15:0] i_h_result,
   output logic o_sda_out,
   output logic o_sda_oe,
   output logic [1:0] o_meas_launch,
   output logic o_system_awake
);

   logic scl_f;
   logic sda_f;
   logic scl_d_reg;
   logic sda_d_reg;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;

   hts_pkg::hts_bus_state_type bus_reg;
   hts_pkg::hts_kind_type kind_reg;
   logic [3:0] cnt_reg;
   logic [7:0] shift_reg;
   logic rw_reg;
   logic ack_reg;
   logic oe_reg;
   logic [7:0] current_reg_pointer;
   logic [7:0] rx_byte;
   logic byte_ack;
   logic rx_done;
   logic wr_strobe;
   logic rd_load;
   logic [7:0] rd_byte;

   logic [7:0] system_control_reg;
   logic [1:0] sensor_run_mode_reg;
   logic [1:0] sensor_launch_reg;
   logic [1:0] sensor_halt_reg;
   logic [1:0] sensor_state_reg;
   logic system_awake_flag;

   hts_pkg::hts_seq_state_type seq_reg;
   logic [15:0] boot_cnt_reg;
   logic [1:0] step_set_reg;
   logic [1:0] step_cont_reg;
   logic [1:0] keep_reg;
   logic [1:0] launch_pulse_reg;
   logic step_end;
   logic step_start;
   logic [1:0] clear_mask;
   logic [16:0] meas_reg [2];
   logic [23:0] t_live;
   logic [23:0] h_live;
   logic [23:0] t_shadow_reg;
   logic [23:0] h_shadow_reg;

   // pin conditioning and bus edge detection
   hts_pin_filter u_filter (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_scl(i_scl),
      .i_sda(i_sda),
      .o_scl(scl_f),
      .o_sda(sda_f)
   ); // RULE25

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_d_reg <= scl_f;
         sda_d_reg <= sda_f;
      end
   end

   // filter delay is a few cycles, far below a 400 kHz half period
   assign scl_rise = scl_f & ~scl_d_reg; // RULE1
   assign scl_fall = ~scl_f & scl_d_reg;
   assign start_cond = scl_f & scl_d_reg & sda_d_reg & ~sda_f;
   assign stop_cond = scl_f & scl_d_reg & ~sda_d_reg & sda_f;

   function automatic logic writable(input logic [7:0] addr);
      return (addr == hts_pkg::ADDR_SYSTEM_CONTROL_REG) || (addr == hts_pkg::ADDR_SENSOR_RUN_MODE_REG) ||
         (addr == hts_pkg::ADDR_SENSOR_LAUNCH_REG) || (addr == hts_pkg::ADDR_SENSOR_HALT_REG);
   endfunction

   assign rx_byte = {shift_reg[6:0], sda_f};

   always_comb begin
      unique case (kind_reg)
         hts_pkg::KIND_ADDR: byte_ack = (rx_byte[7:1] == hts_pkg::SLAVE_ADDR); // RULE3 RULE4
         hts_pkg::KIND_REG: byte_ack = 1'b1; // RULE6
         hts_pkg::KIND_WDATA: byte_ack = writable(current_reg_pointer); // RULE8
         default: byte_ack = 1'b0;
      endcase
   end

   assign rx_done = scl_rise & (bus_reg == hts_pkg::BUS_RX) & (cnt_reg == 4'h7) &
      ~start_cond & ~stop_cond;
   assign wr_strobe = rx_done & (kind_reg == hts_pkg::KIND_WDATA) &
      writable(current_reg_pointer); // RULE7 RULE8
   assign rd_load = scl_fall & ~start_cond & ~stop_cond &
      (((bus_reg == hts_pkg::BUS_ACK_HOLD) & (kind_reg == hts_pkg::KIND_ADDR) & rw_reg) |
      (bus_reg == hts_pkg::BUS_RD_LOAD));

   // bus protocol state
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         bus_reg <= hts_pkg::BUS_IDLE;
         kind_reg <= hts_pkg::KIND_ADDR;
         cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         rw_reg <= 1'b0;
         ack_reg <= 1'b0;
         oe_reg <= 1'b0;
      end else if (start_cond) begin
         bus_reg <= hts_pkg::BUS_RX;
         kind_reg <= hts_pkg::KIND_ADDR;
         cnt_reg <= 4'h0;
         oe_reg <= 1'b0;
      end else if (stop_cond) begin
         bus_reg <= hts_pkg::BUS_IDLE;
         oe_reg <= 1'b0;
      end else begin
         unique case (bus_reg)
            hts_pkg::BUS_IDLE: begin
               oe_reg <= 1'b0;
            end
            hts_pkg::BUS_RX: begin
               if (scl_rise) begin
                  shift_reg <= rx_byte;
                  cnt_reg <= cnt_reg + 4'h1;
                  if (cnt_reg == 4'h7) begin
                     ack_reg <= byte_ack;
                     if (kind_reg == hts_pkg::KIND_ADDR) begin
                        rw_reg <= sda_f;
                     end
                     // foreign address: stay off the bus until the next start
                     if (kind_reg == hts_pkg::KIND_ADDR && !byte_ack) begin
                        bus_reg <= hts_pkg::BUS_IDLE; // RULE4
                     end else begin
                        bus_reg <= hts_pkg::BUS_ACK_SET;
                     end
                  end
               end
            end
            hts_pkg::BUS_ACK_SET: begin
               if (scl_fall) begin
                  oe_reg <= ack_reg;
                  bus_reg <= hts_pkg::BUS_ACK_HOLD;
               end
            end
            hts_pkg::BUS_ACK_HOLD: begin
               if (scl_fall) begin
                  cnt_reg <= 4'h0;
                  if (rd_load) begin
                     shift_reg <= rd_byte;
                     oe_reg <= ~rd_byte[7];
                     bus_reg <= hts_pkg::BUS_TX; // RULE9
                  end else begin
                     oe_reg <= 1'b0;
                     bus_reg <= hts_pkg::BUS_RX;
                     if (kind_reg == hts_pkg::KIND_ADDR) begin
                        kind_reg <= hts_pkg::KIND_REG;
                     end else begin
                        kind_reg <= hts_pkg::KIND_WDATA;
                     end
                  end
               end
            end
            hts_pkg::BUS_TX: begin
               if (scl_rise) begin
                  cnt_reg <= cnt_reg + 4'h1;
               end
               if (scl_fall) begin
                  if (cnt_reg == 4'h8) begin
                     oe_reg <= 1'b0;
                     bus_reg <= hts_pkg::BUS_MACK;
                  end else begin
                     oe_reg <= ~shift_reg[6];
                     shift_reg <= {shift_reg[6:0], 1'b0};
                  end
               end
            end
            hts_pkg::BUS_MACK: begin
               if (scl_rise) begin
                  // a nack from the master ends the read; wait for its stop
                  bus_reg <= sda_f ? hts_pkg::BUS_IDLE : hts_pkg::BUS_RD_LOAD; // RULE9
               end
            end
            hts_pkg::BUS_RD_LOAD: begin
               if (scl_fall) begin
                  cnt_reg <= 4'h0;
                  shift_reg <= rd_byte;
                  oe_reg <= ~rd_byte[7];
                  bus_reg <= hts_pkg::BUS_TX;
               end
            end
            default: begin
               bus_reg <= hts_pkg::BUS_IDLE;
               oe_reg <= 1'b0;
            end
         endcase
      end
   end

   // register pointer with auto increment
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         current_reg_pointer <= 8'h00;
      end else if (rx_done && kind_reg == hts_pkg::KIND_REG) begin
         current_reg_pointer <= rx_byte; // RULE5 RULE6
      end else if ((rx_done && kind_reg == hts_pkg::KIND_WDATA) || rd_load) begin
         current_reg_pointer <= current_reg_pointer + 8'h01; // RULE7 RULE9
      end
   end

   // readout words: crc over data and valid sits above them
   assign t_live = {hts_pkg::crc7(meas_reg[hts_pkg::SENS_T]), meas_reg[hts_pkg::SENS_T]}; // RULE23
   assign h_live = {hts_pkg::crc7(meas_reg[hts_pkg::SENS_H]), meas_reg[hts_pkg::SENS_H]};

   always_comb begin
      unique case (current_reg_pointer)
         hts_pkg::ADDR_SYSTEM_CONTROL_REG: rd_byte = system_control_reg;
         hts_pkg::ADDR_SYS_STAT: rd_byte = {7'h00, system_awake_flag};
         hts_pkg::ADDR_SENSOR_RUN_MODE_REG: rd_byte = {6'h00, sensor_run_mode_reg};
         hts_pkg::ADDR_SENSOR_LAUNCH_REG: rd_byte = {6'h00, sensor_launch_reg};
         hts_pkg::ADDR_SENSOR_HALT_REG: rd_byte = {6'h00, sensor_halt_reg};
         hts_pkg::ADDR_SENSOR_STATE_REG: rd_byte = {6'h00, sensor_state_reg}; // RULE13
         hts_pkg::ADDR_T_VAL0: rd_byte = t_live[7:0]; // RULE24
         hts_pkg::ADDR_T_VAL1: rd_byte = t_shadow_reg[15:8];
         hts_pkg::ADDR_T_VAL2: rd_byte = t_shadow_reg[23:16];
         hts_pkg::ADDR_H_VAL0: rd_byte = h_live[7:0];
         hts_pkg::ADDR_H_VAL1: rd_byte = h_shadow_reg[15:8];
         hts_pkg::ADDR_H_VAL2: rd_byte = h_shadow_reg[23:16];
         default: rd_byte = 8'h00; // RULE10
      endcase
   end

   // snapshot keeps the three bytes of one result together
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         t_shadow_reg <= 24'h000000;
         h_shadow_reg <= 24'h000000;
      end else if (rd_load) begin
         if (current_reg_pointer == hts_pkg::ADDR_T_VAL0) begin
            t_shadow_reg <= t_live; // RULE24
         end
         if (current_reg_pointer == hts_pkg::ADDR_H_VAL0) begin
            h_shadow_reg <= h_live;
         end
      end
   end

   // control registers; a bus set wins over the sequencer's clear
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         system_control_reg <= hts_pkg::SYSTEM_CONTROL_REG_RST;
         sensor_run_mode_reg <= hts_pkg::SENS_BITS_RST;
         sensor_launch_reg <= hts_pkg::SENS_BITS_RST;
         sensor_halt_reg <= hts_pkg::SENS_BITS_RST;
      end else begin
         if (wr_strobe && current_reg_pointer == hts_pkg::ADDR_SYSTEM_CONTROL_REG) begin
            system_control_reg <= {7'h00, rx_byte[hts_pkg::LOW_POWER_BIT]};
         end
         if (wr_strobe && current_reg_pointer == hts_pkg::ADDR_SENSOR_RUN_MODE_REG) begin
            sensor_run_mode_reg <= rx_byte[1:0]; // RULE11
         end
         if (wr_strobe && current_reg_pointer == hts_pkg::ADDR_SENSOR_LAUNCH_REG) begin
            sensor_launch_reg <= (sensor_launch_reg & ~clear_mask) | rx_byte[1:0]; // RULE16
         end else begin
            sensor_launch_reg <= sensor_launch_reg & ~clear_mask; // RULE18 RULE20
         end
         // a stop for a single-shot sensor is dropped at the write
         if (wr_strobe && current_reg_pointer == hts_pkg::ADDR_SENSOR_HALT_REG) begin
            sensor_halt_reg <= (sensor_halt_reg & ~clear_mask) |
               (rx_byte[1:0] & sensor_run_mode_reg); // RULE12 RULE16
         end else begin
            sensor_halt_reg <= sensor_halt_reg & ~clear_mask;
         end
      end
   end

   // step boundaries: where the launch, mode and stop bits are taken into a step
   assign step_start = (seq_reg == hts_pkg::SEQ_ACTIVE) & (|sensor_launch_reg); // RULE21
   assign step_end = (seq_reg == hts_pkg::SEQ_MEASURE) &
      ((sensor_state_reg & ~i_meas_done) == 2'h0);
   assign clear_mask = step_end ? (step_set_reg & ~(step_cont_reg & ~sensor_halt_reg)) :
      2'h0; // RULE14 RULE16

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         seq_reg <= hts_pkg::SEQ_STANDBY;
         boot_cnt_reg <= 16'h0000;
         sensor_state_reg <= 2'h0;
         step_set_reg <= 2'h0;
         step_cont_reg <= 2'h0;
         keep_reg <= 2'h0;
         launch_pulse_reg <= 2'h0;
      end else begin
         launch_pulse_reg <= 2'h0;
         unique case (seq_reg)
            hts_pkg::SEQ_STANDBY: begin
               boot_cnt_reg <= 16'h0000;
               if ((|sensor_launch_reg) || !system_control_reg[hts_pkg::LOW_POWER_BIT]) begin
                  seq_reg <= hts_pkg::SEQ_BOOT; // RULE17
               end
            end
            hts_pkg::SEQ_BOOT: begin
               boot_cnt_reg <= boot_cnt_reg + 16'h0001;
               if (boot_cnt_reg == 16'(BOOT_CYCLES - 1)) begin
                  seq_reg <= hts_pkg::SEQ_ACTIVE;
               end
            end
            hts_pkg::SEQ_ACTIVE: begin
               if (step_start) begin
                  seq_reg <= hts_pkg::SEQ_MEASURE;
                  sensor_state_reg <= sensor_launch_reg; // RULE13 RULE17
                  step_set_reg <= sensor_launch_reg;
                  step_cont_reg <= sensor_launch_reg & sensor_run_mode_reg; // RULE11 RULE21
                  launch_pulse_reg <= sensor_launch_reg; // RULE16
               end else if (system_control_reg[hts_pkg::LOW_POWER_BIT]) begin
                  seq_reg <= hts_pkg::SEQ_STANDBY; // RULE15
                  keep_reg <= 2'h0;
               end
            end
            hts_pkg::SEQ_MEASURE: begin
               sensor_state_reg <= sensor_state_reg & ~i_meas_done;
               if (step_end) begin
                  seq_reg <= hts_pkg::SEQ_ACTIVE; // RULE15
                  keep_reg <= step_set_reg & step_cont_reg & ~sensor_halt_reg; // RULE19
               end
            end
            default: begin
               seq_reg <= hts_pkg::SEQ_STANDBY;
            end
         endcase
      end
   end

   // results; valid drops only for a sensor starting afresh
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         meas_reg[hts_pkg::SENS_T] <= 17'h00000;
         meas_reg[hts_pkg::SENS_H] <= 17'h00000;
      end else begin
         for (int i = 0; i < hts_pkg::NUM_SENS; i++) begin
            if (step_start && sensor_launch_reg[i] && !keep_reg[i]) begin
               meas_reg[i][hts_pkg::VALID_BIT] <= 1'b0; // RULE17
            end else if (seq_reg == hts_pkg::SEQ_MEASURE && sensor_state_reg[i] &&
               i_meas_done[i]) begin
               meas_reg[i] <= {1'b1, (i == hts_pkg::SENS_T) ? i_t_result : i_h_result}; // RULE18 RULE19 RULE20
            end
         end
      end
   end

   assign system_awake_flag = seq_reg[1];
   assign o_system_awake = system_awake_flag;
   assign o_meas_launch = launch_pulse_reg;
   assign o_sda_out = 1'b0;
   assign o_sda_oe = oe_reg; // RULE2

endmodule

// ===== hw/hts_pin_filter.sv
// two-stage synchroniser and glitch filter for the serial clock and data pins
module hts_pin_filter (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda
);

   logic [1:0] meta_reg;
   logic [1:0] sync_reg;
   logic [1:0] out_reg;
   logic [1:0] cnt_reg [2];

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         meta_reg <= 2'h3;
         sync_reg <= 2'h3;
      end else begin
         meta_reg <= {i_sda, i_scl};
         sync_reg <= meta_reg;
      end
   end

   // a level must hold a few cycles before it is believed; spikes are dropped
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         out_reg <= 2'h3;
         cnt_reg[0] <= 2'h0;
         cnt_reg[1] <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (sync_reg[i] == out_reg[i]) begin
               cnt_reg[i] <= 2'h0;
            end else if (cnt_reg[i] == hts_pkg::FILT_LEN - 2'h1) begin
               out_reg[i] <= sync_reg[i];
               cnt_reg[i] <= 2'h0;
            end else begin
               cnt_reg[i] <= cnt_reg[i] + 2'h1;
            end
         end
      end
   end

   assign o_scl = out_reg[0];
   assign o_sda = out_reg[1];

endmodule

// ===== hw/hts_pkg.sv
// shared constants, types and the checksum function for the sensor slave
package hts_pkg;

   // bus address and register map
   localparam logic [6:0] SLAVE_ADDR = 7'h43;
   localparam logic [7:0] ADDR_SYSTEM_CONTROL_REG = 8'h10;
   localparam logic [7:0] ADDR_SYS_STAT = 8'h11;
   localparam logic [7:0] ADDR_SENSOR_RUN_MODE_REG = 8'h21;
   localparam logic [7:0] ADDR_SENSOR_LAUNCH_REG = 8'h22;
   localparam logic [7:0] ADDR_SENSOR_HALT_REG = 8'h23;
   localparam logic [7:0] ADDR_SENSOR_STATE_REG = 8'h24;
   localparam logic [7:0] ADDR_T_VAL0 = 8'h30;
   localparam logic [7:0] ADDR_T_VAL1 = 8'h31;
   localparam logic [7:0] ADDR_T_VAL2 = 8'h32;
   localparam logic [7:0] ADDR_H_VAL0 = 8'h33;
   localparam logic [7:0] ADDR_H_VAL1 = 8'h34;
   localparam logic [7:0] ADDR_H_VAL2 = 8'h35;

   // field positions and reset values
   localparam int unsigned LOW_POWER_BIT = 0;
   localparam int unsigned AWAKE_BIT = 0;
   localparam int unsigned SENS_T = 0;
   localparam int unsigned SENS_H = 1;
   localparam int unsigned NUM_SENS = 2;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned VALID_BIT = 16;
   localparam logic [7:0] SYSTEM_CONTROL_REG_RST = 8'h01;
   localparam logic [1:0] SENS_BITS_RST = 2'h0;

   // timing
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned BOOT_TIME_US = 1000;
   localparam int unsigned BOOT_CYCLES_DEF = BOOT_TIME_US * (CLK_HZ / 1_000_000);
   localparam logic [1:0] FILT_LEN = 2'h3;

   // checksum
   localparam logic [7:0] CRC_POLY = 8'h89;
   localparam logic [6:0] CRC_INIT = 7'h7f;

   typedef enum logic [2:0] {
      BUS_IDLE = 3'b000,
      BUS_RX = 3'b001,
      BUS_ACK_SET = 3'b010,
      BUS_ACK_HOLD = 3'b011,
      BUS_TX = 3'b100,
      BUS_MACK = 3'b101,
      BUS_RD_LOAD = 3'b110
   } hts_bus_state_type;

   typedef enum logic [1:0] {
      KIND_ADDR = 2'b00,
      KIND_REG = 2'b01,
      KIND_WDATA = 2'b10
   } hts_kind_type;

   typedef enum logic [1:0] {
      SEQ_STANDBY = 2'b00,
      SEQ_BOOT = 2'b01,
      SEQ_ACTIVE = 2'b10,
      SEQ_MEASURE = 2'b11
   } hts_seq_state_type;

   // crc-7 over 16 data bits plus valid flag, x7+x3+1, start 0x7f
   function automatic logic [6:0] crc7(input logic [16:0] payload);
      logic [23:0] val;
      logic [23:0] pol;
      val = {payload, CRC_INIT};
      pol = {CRC_POLY, 16'h0000};
      for (int i = 23; i >= 7; i--) begin
         if (val[i]) begin
            val = val ^ pol;
         end
         pol = pol >> 1;
      end
      return val[6:0];
   endfunction

endpackage

// ===== tb/hts_i2c_master_model.sv
// bus master model driving the serial link
module hts_i2c_master_model (
   input wire logic i_ref_clk,
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_low
);
   timeunit 1ns;
   timeprecision 1ps;
   // clock idles high between frames
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge i_ref_clk);
   endtask
   // start, repeated start and stop share one shape
   task automatic cond(input logic first, input logic second);
      logic r;
      bit_io(~first, r);
      o_sda_low <= second;
      wt(8);
   endtask
   // low phase outlasts the slave's filter delay
   task automatic bit_io(input logic b, output logic r);
      o_scl <= 1'b0;
      wt(4);
      o_sda_low <= ~b;
      wt(6);
      o_scl <= 1'b1;
      wt(8);
      r = i_sda;
   endtask
   task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                       output logic ack_out);
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], rx[i]);
      end
      bit_io(ack_in, ack_out);
   endtask
endmodule

// ===== tb/hts_i2c_sensor_ctrl_sva.sv
// assertion checker watching the sensor slave ports
module hts_i2c_sensor_ctrl_sva #(
   parameter int unsigned BOOT_CYCLES = 20
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic [1:0] i_meas_done,
   input wire logic [15:0] i_t_result,
   input wire logic [15:0] i_h_result,
   input wire logic o_sda_out,
   input wire logic o_sda_oe,
   input wire logic [1:0] o_meas_launch,
   input wire logic o_system_awake
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   logic [1:0] busy_reg;
   logic [15:0] low_reg;
   // launched, not yet done
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         busy_reg <= 2'h0;
      end else begin
         busy_reg <= (busy_reg | o_meas_launch) & ~i_meas_done;
      end
   end
   // asleep cycle count, saturating
   always_ff @(posedge i_ref_clk) begin
      if (i_rst || o_system_awake) begin
         low_reg <= 16'h0;
      end else if (low_reg != 16'hffff) begin
         low_reg <= low_reg + 16'h1;
      end
   end
   property p_reset_quiet;
      disable iff (1'b0) i_rst |=> (!o_sda_oe && o_meas_launch == 2'h0 && !o_system_awake);
   endproperty
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("outputs active after reset");
   property p_oe_scl_low;
      $changed(o_sda_oe) |-> (!i_scl && !$past(i_scl, 3));
   endproperty
   a_oe_scl_low: assert property (p_oe_scl_low)
      else $error("data changed outside clock low");
   property p_sda_out_low;
      o_sda_oe |-> !o_sda_out;
   endproperty
   a_sda_out_low: assert property (p_sda_out_low)
      else $error("data line driven high");
   property p_launch_pulse;
      (o_meas_launch != 2'h0) |=> (o_meas_launch == 2'h0);
   endproperty
   a_launch_pulse: assert property (p_launch_pulse)
      else $error("launch longer than one cycle");
   property p_launch_awake;
      (o_meas_launch != 2'h0) |-> o_system_awake;
   endproperty
   a_launch_awake: assert property (p_launch_awake)
      else $error("launch while asleep");
   property p_boot_time;
      $rose(o_system_awake) |-> (low_reg >= 16'(BOOT_CYCLES - 1));
   endproperty
   a_boot_time: assert property (p_boot_time)
      else $error("awake before boot time");
   property p_no_relaunch;
      (o_meas_launch & busy_reg) == 2'h0;
   endproperty
   a_no_relaunch: assert property (p_no_relaunch)
      else $error("launch during running measurement");
   property p_step_end;
      (busy_reg != 2'h0 && (busy_reg & ~i_meas_done) == 2'h0)
         |-> ##[1:4] (o_meas_launch != 2'h0 || !o_system_awake);
   endproperty
   a_step_end: assert property (p_step_end)
      else $error("step end neither relaunched nor slept");
   property p_sleep_idle;
      $fell(o_system_awake) |-> (busy_reg == 2'h0);
   endproperty
   a_sleep_idle: assert property (p_sleep_idle)
      else $error("standby during measurement");
   c_launch_t: cover property (o_meas_launch[0]);
   c_launch_h: cover property (o_meas_launch[1]);
   c_ack: cover property ($rose(o_sda_oe));
endmodule

bind hts_i2c_sensor_ctrl hts_i2c_sensor_ctrl_sva #(.BOOT_CYCLES(BOOT_CYCLES))
   hts_i2c_sensor_ctrl_sva_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_scl(i_scl),
   .i_sda(i_sda), .i_meas_done(i_meas_done), .i_t_result(i_t_result),
   .i_h_result(i_h_result), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
   .o_meas_launch(o_meas_launch), .o_system_awake(o_system_awake));

// ===== tb/tb_top.sv
// self-checking bench for the sensor slave
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned BOOT = 20;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [1:0] done = 2'h0;
   logic [15:0] t_res = 16'h0;
   logic [15:0] h_res = 16'h0;
   logic sda_out, sda_oe, awake, scl, m_low, sda, nak;
   logic [7:0] rx;
   logic [1:0] launch;
   logic [1:0] mask = 2'h0;
   logic [7:0] bad [3] = '{8'h88, 8'h00, 8'hf0};
   int failures = 0;
   int check_count = 0;
   int launches = 0;
   int cycles = 0;
   always #20 clk = ~clk;
   assign sda = (sda_oe ? sda_out : 1'b1) & ~m_low;
   hts_i2c_sensor_ctrl #(.BOOT_CYCLES(BOOT)) hts_i2c_sensor_ctrl_i (.i_ref_clk(clk),
      .i_rst(rst), .i_scl(scl), .i_sda(sda), .i_meas_done(done), .i_t_result(t_res),
      .i_h_result(h_res), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_meas_launch(launch),
      .o_system_awake(awake));
   hts_i2c_master_model m (.i_ref_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(m_low));
   task automatic give_verdict();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (launch != 2'h0) begin
         launches <= launches + 1;
         mask <= launch;
      end
      if (cycles == 60000) begin
         failures = failures + 1;
         give_verdict();
      end
   end
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // n bytes, low first; nk: expected nack per byte
   task automatic reg_wr(input logic [7:0] a, input logic [23:0] d, input int n,
                         input logic [2:0] nk);
      logic [7:0] r;
      logic k;
      m.cond(1'b0, 1'b1);
      m.xfer(8'h86, 1'b1, r, k);
      chk(24'(k), 24'h0);
      m.xfer(a, 1'b1, r, k);
      chk(24'(k), 24'h0);
      for (int i = 0; i < n; i++) begin
         m.xfer(d[8*i +: 8], 1'b1, r, k);
         chk(24'(k), 24'(nk[i]));
      end
      m.cond(1'b1, 1'b0);
   endtask
   task automatic reg_rd(input logic [7:0] a, input int n, input logic [23:0] e);
      logic [7:0] r;
      logic k;
      m.cond(1'b0, 1'b1);
      m.xfer(8'h86, 1'b1, r, k);
      m.xfer(a, 1'b1, r, k);
      m.cond(1'b0, 1'b1);
      m.xfer(8'h87, 1'b1, r, k);
      chk(24'(k), 24'h0);
      for (int i = 0; i < n; i++) begin
         m.xfer(8'hff, (i == n - 1), r, k);
         chk(24'(r), 24'(e[8*i +: 8]));
      end
      m.cond(1'b1, 1'b0);
   endtask
   task automatic wait_launch(input int n, input logic [1:0] e);
      for (int i = 0; i < 400 && launches < n; i++) begin
         @(posedge clk);
      end
      chk(24'(launches), 24'(n));
      chk(24'(mask), 24'(e));
      chk(24'(awake), 24'h1);
   endtask
   // done pulse, then three boots of quiet so a stray relaunch shows
   task automatic meas_end(input logic [1:0] s, input logic [15:0] v, input int n);
      done <= s;
      t_res <= v;
      h_res <= v;
      @(posedge clk);
      done <= 2'h0;
      repeat (BOOT * 3) @(posedge clk);
      chk(24'(launches), 24'(n));
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (5) @(posedge clk);
      reg_rd(hts_pkg::ADDR_SYSTEM_CONTROL_REG, 2, {16'h0, hts_pkg::SYSTEM_CONTROL_REG_RST});
      reg_rd(8'h22, 3, 24'h0);
      reg_rd(8'hff, 2, 24'h0);
      reg_rd(8'h31, 2, 24'h0);
      $display("reset and read test done");
      reg_wr(8'h20, 24'h0, 2, 3'b001);
      reg_wr(8'h11, 24'hff, 1, 3'b001);
      reg_rd(8'h11, 1, 24'h0);
      foreach (bad[i]) begin
         m.cond(1'b0, 1'b1);
         m.xfer(bad[i], 1'b1, rx, nak);
         chk(24'(nak), 24'h1);
         m.cond(1'b1, 1'b0);
      end
      $display("write and address test done");
      reg_wr(8'h22, 24'h01, 1, 3'b0);
      wait_launch(1, 2'b01);
      reg_rd(8'h24, 1, 24'h1);
      reg_wr(8'h22, 24'h0301, 2, 3'b0);
      meas_end(2'b01, 16'h49fd, 1);
      chk(24'(awake), 24'h0);
      reg_rd(8'h30, 3, 24'h0b49fd);
      reg_rd(8'h22, 3, 24'h0);
      $display("single shot test done");
      // stop stays low while continuous mode is chosen
      reg_wr(8'h21, 24'h0202, 2, 3'b0);
      wait_launch(2, 2'b10);
      meas_end(2'b10, 16'h2e6c, 3);
      reg_rd(8'h33, 3, 24'hf52e6c);
      reg_wr(8'h23, 24'h02, 1, 3'b0);
      meas_end(2'b10, 16'h1234, 3);
      chk(24'(awake), 24'h0);
      reg_rd(8'h33, 2, 24'h1234);
      reg_rd(8'h22, 2, 24'h0);
      $display("continuous test done");
      reg_wr(8'h21, 24'h010101, 3, 3'b0);
      wait_launch(4, 2'b01);
      meas_end(2'b01, 16'h0001, 4);
      chk(24'(awake), 24'h0);
      $display("start with stop test done");
      give_verdict();
   end
endmodule
